// [rtl/pcw_path.sv]
/*
 * Pixel combine and write path. Merges each source word with the
 * destination word pixel by pixel, applies transparency and the plane mask,
 * and presents the word to be written one cycle later.
 * Assumes pixel words and register strobes come from logic on clk_i.
 */
`default_nettype none

module pcw_path
    import pcw_pkg::*;
#(
    parameter bit FULL_TRANSP = 1'b1
) (
    // Clock, reset and enable
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    input  wire logic                ce_i,
    // Register port
    input  wire logic [7:0]          reg_addr_i,
    input  wire logic [WORD_W-1:0]   reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    output var  logic [WORD_W-1:0]   reg_rdata_o,
    // Pixel stream
    input  wire logic                pix_valid_i,
    input  wire logic [WORD_W-1:0]   pix_src_i,
    input  wire logic [WORD_W-1:0]   pix_dst_i,
    input  wire logic [3:0]          pat_row_i,
    // Write side
    output var  logic                wr_valid_o,
    output var  logic [WORD_W-1:0]   wr_data_o,
    output var  logic [NPIX-1:0]     wr_pix_en_o,
    output var  logic                src_screen_o,
    output var  logic [WORD_W-1:0]   pat_addr_o
);

    // ------------------------------------------------------------------
    // Pixel combine function
    // ------------------------------------------------------------------
    function automatic logic [PIX_W-1:0] pcw_combine(
        input logic [4:0]       op,
        input logic [PIX_W-1:0] s,
        input logic [PIX_W-1:0] d
    );
        logic [PIX_W:0]   sum;
        logic [PIX_W-1:0] r;
        sum = {1'b0, s} + {1'b0, d};
        r   = '0;
        case (op)
            OP_SRC:    r = s;
            OP_AND:    r = s & d;
            OP_ANDND:  r = s & ~d;
            OP_ZERO:   r = '0;
            OP_ORND:   r = s | ~d;
            OP_XNOR:   r = ~(s ^ d);
            OP_NDST:   r = ~d;
            OP_NOR:    r = ~(s | d);
            OP_OR:     r = s | d;
            OP_DST:    r = d;
            OP_XOR:    r = s ^ d;
            OP_NSAND:  r = ~s & d;
            OP_ONES:   r = '1;
            OP_NSOR:   r = ~s | d;
            OP_NAND:   r = ~(s & d);
            OP_NSRC:   r = ~s;
            OP_ADD:    r = sum[PIX_W-1:0];
            OP_SATSUM: r = sum[PIX_W] ? '1 : sum[PIX_W-1:0];
            OP_SUB:    r = d - s;
            OP_SATDIF: r = (d < s) ? '0 : (d - s);
            OP_MAX:    r = (s > d) ? s : d;
            OP_MIN:    r = (s < d) ? s : d;
            default:   r = s;
        endcase
        return r;
    endfunction : pcw_combine

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [4:0]        op_q;
    logic [1:0]        tmode_q;
    logic              ten_q;
    logic [WORD_W-1:0] pmask_q;
    logic [WORD_W-1:0] bgcol_q;
    logic [WORD_W-1:0] srcbas_q;
    logic [WORD_W-1:0] srcpit_q;
    logic [WORD_W-1:0] patptr_q;
    logic [15:0]       supp_cnt_q;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire logic wr_ctrl   = ce_i && reg_wr_i && (reg_addr_i == OFS_CTRL);
    wire logic wr_pmask  = ce_i && reg_wr_i && (reg_addr_i == OFS_PMASK);
    wire logic wr_bgcol  = ce_i && reg_wr_i && (reg_addr_i == OFS_BGCOL);
    wire logic wr_srcbas = ce_i && reg_wr_i && (reg_addr_i == OFS_SRCBAS);
    wire logic wr_srcpit = ce_i && reg_wr_i && (reg_addr_i == OFS_SRCPIT);
    wire logic wr_patptr = ce_i && reg_wr_i && (reg_addr_i == OFS_PATPTR);

    wire logic [4:0] new_op    = reg_wdata_i[CTRL_OP_LSB +: 5];
    wire logic [1:0] new_tmode = reg_wdata_i[CTRL_TM_LSB +: 2];
    // An out-of-range select is dropped so the datapath never sees one.
    wire logic       op_ok     = (new_op <= OP_LAST);
    // The reduced variant pins the mode to the zero-result test.
    wire logic [1:0] tmode_d   = FULL_TRANSP ? new_tmode : TM_RES_ZERO;

    wire logic       pitch_bad = (srcpit_q[3:0] != 4'h0);
    wire logic       src_scr   = (srcbas_q == RST_WORD);

    wire logic [WORD_W-1:0] ctrl_rd =
        {24'h0, ten_q, tmode_q, op_q};
    wire logic [WORD_W-1:0] stat_rd =
        {supp_cnt_q, 14'h0, pitch_bad, src_scr};

    logic [WORD_W-1:0] rd_sel;
    always_comb begin
        if (reg_addr_i == OFS_CTRL) begin
            rd_sel = ctrl_rd;
        end else if (reg_addr_i == OFS_PMASK) begin
            rd_sel = pmask_q;
        end else if (reg_addr_i == OFS_BGCOL) begin
            rd_sel = bgcol_q;
        end else if (reg_addr_i == OFS_SRCBAS) begin
            rd_sel = srcbas_q;
        end else if (reg_addr_i == OFS_SRCPIT) begin
            rd_sel = srcpit_q;
        end else if (reg_addr_i == OFS_PATPTR) begin
            rd_sel = patptr_q;
        end else if (reg_addr_i == OFS_STATUS) begin
            rd_sel = stat_rd;
        end else begin
            rd_sel = RST_WORD;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_q    <= RST_OP;
            tmode_q <= RST_TMODE;
            ten_q   <= 1'b0;
        end else if (wr_ctrl) begin
            if (op_ok) begin
                op_q <= new_op;
            end
            tmode_q <= tmode_d;
            ten_q   <= reg_wdata_i[CTRL_TEN_BIT];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pmask_q  <= RST_WORD;
            bgcol_q  <= RST_WORD;
            srcbas_q <= RST_WORD;
            srcpit_q <= RST_WORD;
            patptr_q <= RST_WORD;
        end else begin
            if (wr_pmask)  pmask_q  <= reg_wdata_i;
            if (wr_bgcol)  bgcol_q  <= reg_wdata_i;
            if (wr_srcbas) srcbas_q <= reg_wdata_i;
            if (wr_srcpit) srcpit_q <= reg_wdata_i;
            if (wr_patptr) patptr_q <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= RST_WORD;
        end else if (ce_i) begin
            reg_rdata_o <= reg_rd_i ? rd_sel : RST_WORD;
        end
    end

    // ------------------------------------------------------------------
    // Per-pixel datapath
    // ------------------------------------------------------------------
    logic [WORD_W-1:0] res_w;
    logic [NPIX-1:0]   hit_w;

    genvar g;
    generate
        for (g = 0; g < NPIX; g++) begin : g_lane
            wire logic [PIX_W-1:0] s  = pix_src_i[g*PIX_W +: PIX_W];
            wire logic [PIX_W-1:0] d  = pix_dst_i[g*PIX_W +: PIX_W];
            wire logic [PIX_W-1:0] bg = bgcol_q[g*PIX_W +: PIX_W];
            wire logic [PIX_W-1:0] r  = pcw_combine(op_q, s, d);
            assign res_w[g*PIX_W +: PIX_W] = r;
            assign hit_w[g] = (tmode_q == TM_SRC_ZERO) ? (s == '0) :
                              (tmode_q == TM_SRC_BG)   ? (s == bg) :
                              (tmode_q == TM_RES_ZERO) ? (r == '0) :
                                                         (r == bg);
        end
    endgenerate

    // Protected planes take the old destination bits back in.
    wire logic [WORD_W-1:0] wr_data_d = (pmask_q & pix_dst_i) | (~pmask_q & res_w);
    wire logic [NPIX-1:0]   pix_en_d  = ten_q ? ~hit_w : '1;
    wire logic [WORD_W-1:0] pat_d     = patptr_q + {24'h0, pat_row_i, 4'h0};

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_valid_o   <= 1'b0;
            wr_data_o    <= RST_WORD;
            wr_pix_en_o  <= '0;
            src_screen_o <= 1'b1;
            pat_addr_o   <= RST_WORD;
            supp_cnt_q   <= '0;
        end else if (ce_i) begin
            wr_valid_o   <= pix_valid_i;
            wr_data_o    <= wr_data_d;
            wr_pix_en_o  <= pix_valid_i ? pix_en_d : '0;
            src_screen_o <= src_scr;
            pat_addr_o   <= pat_d;
            if (pix_valid_i && (pix_en_d != '1)) begin
                supp_cnt_q <= supp_cnt_q + 16'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    op_range_a: assert property (op_q <= OP_LAST)
        else $error("operation select out of range");

    src_copy_a: assert property (
        (ce_i && pix_valid_i && op_q == OP_SRC && pmask_q == '0)
        |=> wr_data_o == $past(pix_src_i))
        else $error("copy operation wrong");

    xor_op_a: assert property (
        (ce_i && pix_valid_i && op_q == OP_XOR && pmask_q == '0)
        |=> wr_data_o == ($past(pix_src_i) ^ $past(pix_dst_i)))
        else $error("xor operation wrong");

    add_wrap_a: assert property (
        (ce_i && pix_valid_i && op_q == OP_ADD && pmask_q == '0)
        |=> wr_data_o[7:0] == 8'($past(pix_src_i[7:0]) + $past(pix_dst_i[7:0])))
        else $error("wrapping sum wrong");

    sat_sum_a: assert property (
        (ce_i && pix_valid_i && op_q == OP_SATSUM && pmask_q == '0 &&
         ({1'b0, pix_src_i[7:0]} + {1'b0, pix_dst_i[7:0]}) > 9'h0ff)
        |=> wr_data_o[7:0] == 8'hff)
        else $error("saturating sum did not clamp");

    sat_dif_a: assert property (
        (ce_i && pix_valid_i && op_q == OP_SATDIF && pmask_q == '0 &&
         pix_dst_i[7:0] < pix_src_i[7:0])
        |=> wr_data_o[7:0] == 8'h00)
        else $error("saturating difference did not clamp");

    plane_keep_a: assert property (
        (ce_i && pix_valid_i)
        |=> (wr_data_o & $past(pmask_q)) == ($past(pix_dst_i) & $past(pmask_q)))
        else $error("protected plane modified");

    mask_read_a: assert property (
        (ce_i && reg_rd_i && reg_addr_i == OFS_PMASK)
        |=> reg_rdata_o == $past(pmask_q))
        else $error("plane mask read back wrong");

    transp_src_a: assert property (
        (ce_i && pix_valid_i && ten_q && tmode_q == TM_SRC_ZERO &&
         pix_src_i[15:8] == 8'h00)
        |=> !wr_pix_en_o[1] ##0 wr_valid_o)
        else $error("zero source not suppressed");

    transp_res_a: assert property (
        (ce_i && pix_valid_i && ten_q && tmode_q == TM_RES_ZERO && op_q == OP_XOR &&
         pix_src_i[7:0] == pix_dst_i[7:0])
        |=> !wr_pix_en_o[0] ##0 wr_valid_o)
        else $error("zero result not suppressed");

    reduced_mode_a: assert property (
        !FULL_TRANSP |-> tmode_q == TM_RES_ZERO)
        else $error("reduced variant left zero-result mode");

    screen_sel_a: assert property (
        ce_i |=> src_screen_o == ($past(srcbas_q) == RST_WORD))
        else $error("screen source select wrong");

    pat_addr_a: assert property (
        ce_i |=> pat_addr_o == $past(patptr_q) + {24'h0, $past(pat_row_i), 4'h0})
        else $error("pattern row address wrong");

endmodule : pcw_path

`default_nettype wire

// [rtl/pcw_pkg.sv]
/*
 * Constants for the pixel combine and write path: register map, field
 * positions, reset values and the codes of the pixel operations.
 * Assumes a 32-bit register port addressed in bytes, one word per register.
 */
`default_nettype none

package pcw_pkg;

    // ------------------------------------------------------------------
    // Pixel geometry
    // ------------------------------------------------------------------
    localparam int unsigned PIX_W    = 8;
    localparam int unsigned WORD_W   = 32;
    localparam int unsigned NPIX     = WORD_W / PIX_W;
    localparam int unsigned PAT_SIDE = 16;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_PMASK  = 8'h04;
    localparam logic [7:0] OFS_BGCOL  = 8'h08;
    localparam logic [7:0] OFS_SRCBAS = 8'h0c;
    localparam logic [7:0] OFS_SRCPIT = 8'h10;
    localparam logic [7:0] OFS_PATPTR = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // ------------------------------------------------------------------
    // Control and status fields
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_OP_LSB   = 0;
    localparam int unsigned CTRL_TM_LSB   = 5;
    localparam int unsigned CTRL_TEN_BIT  = 7;
    localparam int unsigned STAT_SCR_BIT  = 0;
    localparam int unsigned STAT_PIT_BIT  = 1;
    localparam int unsigned STAT_CNT_LSB  = 16;

    // ------------------------------------------------------------------
    // Reset values and the highest operation code
    // ------------------------------------------------------------------
    localparam logic [4:0]  RST_OP    = 5'h00;
    localparam logic [1:0]  RST_TMODE = 2'h2;
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [4:0]  OP_LAST   = 5'h15;

    // ------------------------------------------------------------------
    // Pixel operation codes
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_SRC  = 5'b00000, OP_AND   = 5'b00001, OP_ANDND = 5'b00010,
        OP_ZERO = 5'b00011, OP_ORND  = 5'b00100, OP_XNOR  = 5'b00101,
        OP_NDST = 5'b00110, OP_NOR   = 5'b00111, OP_OR    = 5'b01000,
        OP_DST  = 5'b01001, OP_XOR   = 5'b01010, OP_NSAND = 5'b01011,
        OP_ONES = 5'b01100, OP_NSOR  = 5'b01101, OP_NAND  = 5'b01110,
        OP_NSRC = 5'b01111, OP_ADD   = 5'b10000, OP_SATSUM = 5'b10001,
        OP_SUB  = 5'b10010, OP_SATDIF = 5'b10011, OP_MAX  = 5'b10100,
        OP_MIN  = 5'b10101
    } pcw_op_e;

    // ------------------------------------------------------------------
    // Transparency modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TM_SRC_ZERO = 2'b00,
        TM_SRC_BG   = 2'b01,
        TM_RES_ZERO = 2'b10,
        TM_RES_BG   = 2'b11
    } pcw_tmode_e;

endpackage : pcw_pkg

`default_nettype wire

// [verif/pcw_path_tb.sv]
/*
 * Self-checking bench for the pixel combine and write path: register
 * access, all pixel operations, plane mask, transparency and the
 * reduced variant, source screen select and the pattern row address.
 * Assumes the design package and module are compiled first.
 */
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin failures++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end

module testbench
    import pcw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [31:0] S  = 32'h0530_80ff;
    localparam logic [31:0] D  = 32'hc810_9001;
    localparam logic [31:0] TS = 32'h1255_0033;
    localparam logic [31:0] TD = 32'h4711_0133;

    logic        clk, rst_n, ce, wr, rd, pv;
    logic [7:0]  addr;
    logic [31:0] wdata, src, dst, rdata, rdata_r, wr_data, pat_addr, rq, rqr;
    logic [3:0]  row, en, en_r;
    logic        wr_valid, src_screen;
    logic [3:0]  en_exp [4];
    int          failures, checks_done, cycles;

    pcw_path #(.FULL_TRANSP(1'b1)) uut (
        .clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .pix_valid_i(pv), .pix_src_i(src), .pix_dst_i(dst), .pat_row_i(row),
        .wr_valid_o(wr_valid), .wr_data_o(wr_data), .wr_pix_en_o(en),
        .src_screen_o(src_screen), .pat_addr_o(pat_addr));

    // The reduced variant shares every input; only its read data and enables are watched.
    pcw_path #(.FULL_TRANSP(1'b0)) uut_red (
        .clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata_r),
        .pix_valid_i(pv), .pix_src_i(src), .pix_dst_i(dst), .pat_row_i(row),
        .wr_valid_o(), .wr_data_o(), .wr_pix_en_o(en_r),
        .src_screen_o(), .pat_addr_o());

    always #10 clk = ~clk;

    // --------------------------------------------------------------
    // Reference model and bus tasks
    // --------------------------------------------------------------
    function automatic logic [7:0] op_ref(input logic [4:0] op, input logic [7:0] s,
                                          input logic [7:0] d);
        logic [8:0] sum;
        sum = {1'b0, s} + {1'b0, d};
        case (op)
            5'd0:  return s;
            5'd1:  return s & d;
            5'd2:  return s & ~d;
            5'd3:  return 8'h00;
            5'd4:  return s | ~d;
            5'd5:  return ~(s ^ d);
            5'd6:  return ~d;
            5'd7:  return ~(s | d);
            5'd8:  return s | d;
            5'd9:  return d;
            5'd10: return s ^ d;
            5'd11: return ~s & d;
            5'd12: return 8'hff;
            5'd13: return ~s | d;
            5'd14: return ~(s & d);
            5'd15: return ~s;
            5'd16: return sum[7:0];
            5'd17: return sum[8] ? 8'hff : sum[7:0];
            5'd18: return d - s;
            5'd19: return (d < s) ? 8'h00 : d - s;
            5'd20: return (s > d) ? s : d;
            default: return (s < d) ? s : d;
        endcase
    endfunction : op_ref

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        rq  = rdata;
        rqr = rdata_r;
    endtask : rd_reg

    task automatic px(input logic [31:0] s, input logic [31:0] d);
        @(posedge clk);
        pv  <= 1'b1;
        src <= s;
        dst <= d;
        @(posedge clk);
        pv  <= 1'b0;
        @(negedge clk);
        `CHK("wr_valid", 1'b1, wr_valid)
    endtask : px

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : wrap_up

    // A hang would otherwise never reach the report; the tests need well under this.
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 4000) begin
            failures++;
            wrap_up();
        end
    end

    // --------------------------------------------------------------
    // Test sequence
    // --------------------------------------------------------------
    initial begin
        logic [31:0] exp_w;
        logic [31:0] pm;
        clk = 0; rst_n = 0; ce = 1; wr = 0; rd = 0; pv = 0; addr = 0;
        wdata = 0; src = 0; dst = 0; row = 0;
        en_exp = '{4'hd, 4'hb, 4'he, 4'h7};
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(OFS_CTRL);
        `CHK("ctrl reset", 32'h0000_0040, rq)
        @(negedge clk);
        `CHK("rdata idle", 32'h0, rdata)
        rd_reg(OFS_PMASK);
        `CHK("pmask reset", 32'h0, rq)
        rd_reg(OFS_STATUS);
        `CHK("status reset", 32'h1, rq)
        rd_reg(8'h1c);
        `CHK("unmapped", 32'h0, rq)
        $display("test reset done");

        for (int op = 0; op <= 21; op++) begin
            wr_reg(OFS_CTRL, 32'(op));
            px(S, D);
            for (int i = 0; i < 4; i++)
                exp_w[8*i +: 8] = op_ref(5'(op), S[8*i +: 8], D[8*i +: 8]);
            `CHK("op result", exp_w, wr_data)
            `CHK("op enables", 4'hf, en)
        end
        wr_reg(OFS_CTRL, 32'h0000_0096);
        rd_reg(OFS_CTRL);
        `CHK("op over 21", 32'h0000_0095, rq)
        `CHK("reduced mode", 32'h0000_00d5, rqr)
        $display("test operations done");

        pm = 32'h0f0f_0f0f;
        wr_reg(OFS_PMASK, pm);
        rd_reg(OFS_PMASK);
        `CHK("pmask back", pm, rq)
        wr_reg(OFS_CTRL, 32'h0000_000c);
        px(S, D);
        `CHK("masked ones", (pm & D) | ~pm, wr_data)
        @(negedge clk);
        `CHK("valid drop", 1'b0, wr_valid)
        `CHK("enable drop", 4'h0, en)
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(OFS_PMASK, 32'hffff_ffff);
        ce <= 1'b1;
        rd_reg(OFS_PMASK);
        `CHK("pmask frozen", pm, rq)
        $display("test plane mask done");

        wr_reg(OFS_PMASK, 32'h0);
        wr_reg(OFS_BGCOL, 32'h5555_5555);
        for (int m = 0; m < 4; m++) begin
            wr_reg(OFS_CTRL, {24'h0, 1'b1, 2'(m), 5'd10});
            px(TS, TD);
            `CHK("transp data", TS ^ TD, wr_data)
            `CHK("transp enables", en_exp[m], en)
            `CHK("reduced enables", 4'he, en_r)
        end
        wr_reg(OFS_STATUS, 32'hffff_ffff);
        rd_reg(OFS_STATUS);
        `CHK("suppress count", 32'h0004_0001, rq)
        `CHK("reduced count", 32'h0004_0001, rqr)
        $display("test transparency done");

        wr_reg(OFS_SRCBAS, 32'h0000_1000);
        wr_reg(OFS_SRCPIT, 32'h0000_0100);
        @(posedge clk);
        @(negedge clk);
        `CHK("linear source", 1'b0, src_screen)
        rd_reg(OFS_STATUS);
        `CHK("pitch good", 2'b00, rq[1:0])
        wr_reg(OFS_SRCPIT, 32'h0000_0108);
        rd_reg(OFS_STATUS);
        `CHK("pitch bad", 2'b10, rq[1:0])
        wr_reg(OFS_SRCBAS, 32'h0);
        @(posedge clk);
        @(negedge clk);
        `CHK("screen source", 1'b1, src_screen)
        wr_reg(OFS_PATPTR, 32'h0000_2000);
        row <= 4'hf;
        @(posedge clk);
        @(negedge clk);
        `CHK("pattern row", 32'h0000_20f0, pat_addr)
        $display("test source and pattern done");
        wrap_up();
    end

endmodule : testbench

`default_nettype wire
